// File: hdl/vpsc_pkg.sv
// Package of the video port switch control: sizes, register map, reset values,
// local bus decoder states, the struct that carries per-sink controls and the DDC bus struct.
// Assumes one 200 MHz clock domain with all pin inputs already synchronous.
package vpsc_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_SRC  = 4;
  localparam int NUM_SINK = 2;
  localparam int SEL_W    = 2;
  localparam int BYTE_W   = 8;
  localparam int CNT_W    = 4;

  // ----------------------------------------------------------------------
  // Register map of the local two-wire bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_SINK1_CTRL = 8'h00;
  localparam logic [7:0] REG_SINK2_CTRL = 8'h01;
  localparam logic [7:0] REG_SINK_PWR   = 8'h02;
  localparam logic [4:0] LB_ADDR_BASE   = 5'h16;
  localparam logic [3:0] LB_BYTE_BITS   = 4'h8;

  // Per-sink controls, in dedicated pin order: select low, select high,
  // output enable (low active), DDC drive enable, de-emphasis.
  typedef struct packed {
    logic             deemph_en;
    logic             ddc_drive_en;
    logic             lane_oe_n;
    logic [SEL_W-1:0] src_sel;
  } vpsc_sink_ctrl_s;

  // One DDC bus: clock and data lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } vpsc_ddc_s;

  localparam vpsc_sink_ctrl_s SINK_CTRL_RST = 5'h04;
  localparam logic            SINK_PWR_RST  = 1'b1;

  // ----------------------------------------------------------------------
  // Local bus decoder states
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    LB_IDLE = 9'h001,
    LB_ADDR = 9'h002,
    LB_AACK = 9'h004,
    LB_PTR  = 9'h008,
    LB_PACK = 9'h010,
    LB_WDAT = 9'h020,
    LB_WACK = 9'h040,
    LB_RDAT = 9'h080,
    LB_RACK = 9'h100
  } vpsc_lb_state_e;

endpackage

// File: hdl/vpsc_top.sv
// Control logic of a four-source, two-sink video port switch.
// Assumes pin inputs are synchronous to clk; pad pull-downs and the analogue
// lane drivers sit outside and use the enables and selects driven here.
`timescale 1ns/1ps

module vpsc_top (
  input  wire logic                                          clk,              // 200 MHz clock
  input  wire logic                                          rst_n,            // Async reset
  input  wire logic                                          ctrl_source_sel,  // 1: pins, 0: bus
  input  wire vpsc_pkg::vpsc_sink_ctrl_s [vpsc_pkg::NUM_SINK-1:0] ctrl_pins_in, // Dedicated pins
  input  wire logic                                          local_bus_clk_in, // Bus clock level
  output logic                                               local_bus_clk_out,// Bus clock drive
  output logic                                               local_bus_clk_oe, // Bus clock enable
  input  wire logic                                          local_bus_dat_in, // Bus data level
  output logic                                               local_bus_dat_out,// Bus data drive
  output logic                                               local_bus_dat_oe, // Bus data enable
  input  wire logic                                          local_addr_bit0,  // Address strap 0
  input  wire logic                                          local_addr_bit1,  // Address strap 1
  input  wire logic [vpsc_pkg::NUM_SRC-1:0]                  src_power_sense,  // Source power
  output logic      [vpsc_pkg::NUM_SRC-1:0]                  src_hotplug_out,  // Source hot-plug
  input  wire logic [vpsc_pkg::NUM_SINK-1:0]                 sink_hotplug_in,  // Sink hot-plug
  output logic      [vpsc_pkg::NUM_SINK-1:0]                 sink_power_out,   // Sink power
  output logic      [vpsc_pkg::NUM_SINK-1:0][vpsc_pkg::SEL_W-1:0] sink_lane_sel, // Lane mux
  output logic      [vpsc_pkg::NUM_SINK-1:0]                 sink_lane_en,     // Lane drivers on
  output logic      [vpsc_pkg::NUM_SINK-1:0]                 sink_deemph_en,   // De-emphasis
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0]   src_ddc_in,       // Source DDC level
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0]        src_ddc_out,      // Source DDC drive
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0]        src_ddc_oe,       // Source DDC pull
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0]  sink_ddc_in,      // Sink DDC level
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0]       sink_ddc_out,     // Sink DDC drive
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0]       sink_ddc_oe       // Sink DDC pull
);
  import vpsc_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [NUM_SRC-1:0] src_onehot(input logic [SEL_W-1:0] sel);
    src_onehot = '0;
    src_onehot[sel] = 1'b1;
  endfunction

  vpsc_sink_ctrl_s [NUM_SINK-1:0] ctrl_reg_ff;
  logic                           pwr_en_ff;
  logic [7:0]                     ptr_ff;

  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                          input vpsc_sink_ctrl_s [NUM_SINK-1:0] cr,
                                          input logic pe);
    reg_read = '0;
    if (idx == REG_SINK1_CTRL) begin
      reg_read = {3'h0, cr[0]};
    end else if (idx == REG_SINK2_CTRL) begin
      reg_read = {3'h0, cr[1]};
    end else if (idx == REG_SINK_PWR) begin
      reg_read = {7'h00, pe};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Local two-wire bus slave
  // ----------------------------------------------------------------------
  vpsc_lb_state_e   lb_state_ff;
  logic             scl_prev_ff;
  logic             sda_prev_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic [7:0]       shift_ff;
  logic [7:0]       tx_ff;
  logic             rw_ff;
  logic             sda_oe_ff;
  logic             bus_mode;
  logic             scl_rise;
  logic             scl_fall;
  logic             lb_start;
  logic             lb_stop;
  logic             byte_done;
  logic             wr_stb;
  logic [6:0]       my_addr;
  logic [7:0]       rd_byte;

  assign bus_mode  = !ctrl_source_sel;
  assign scl_rise  = local_bus_clk_in && !scl_prev_ff;
  assign scl_fall  = !local_bus_clk_in && scl_prev_ff;
  assign lb_start  = local_bus_clk_in && scl_prev_ff && sda_prev_ff && !local_bus_dat_in;
  assign lb_stop   = local_bus_clk_in && scl_prev_ff && !sda_prev_ff && local_bus_dat_in;
  assign byte_done = (bit_cnt_ff == LB_BYTE_BITS);
  assign my_addr   = {LB_ADDR_BASE, local_addr_bit1, local_addr_bit0};
  assign wr_stb    = bus_mode && (lb_state_ff == LB_WDAT) && scl_fall && byte_done;
  assign rd_byte   = reg_read(ptr_ff, ctrl_reg_ff, pwr_en_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= local_bus_clk_in;
      sda_prev_ff <= local_bus_dat_in;
    end
  end

  // Bus transaction sequencer; pin mode holds it idle and released.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lb_state_ff <= LB_IDLE;
      bit_cnt_ff  <= '0;
      shift_ff    <= '0;
      tx_ff       <= '0;
      rw_ff       <= 1'b0;
      ptr_ff      <= '0;
      sda_oe_ff   <= 1'b0;
    end else if (!bus_mode) begin
      lb_state_ff <= LB_IDLE;
      sda_oe_ff   <= 1'b0;
    end else if (lb_stop) begin
      lb_state_ff <= LB_IDLE;
      sda_oe_ff   <= 1'b0;
    end else if (lb_start) begin
      lb_state_ff <= LB_ADDR;
      bit_cnt_ff  <= '0;
      sda_oe_ff   <= 1'b0;
    end else begin
      case (lb_state_ff)
        LB_ADDR, LB_PTR, LB_WDAT: begin
          if (scl_rise && !byte_done) begin
            shift_ff   <= {shift_ff[6:0], local_bus_dat_in};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end else if (scl_fall && byte_done) begin
            sda_oe_ff <= 1'b1;
            if (lb_state_ff == LB_ADDR) begin
              rw_ff <= shift_ff[0];
              if (shift_ff[7:1] == my_addr) begin
                lb_state_ff <= LB_AACK;
              end else begin
                lb_state_ff <= LB_IDLE;
                sda_oe_ff   <= 1'b0;
              end
            end else if (lb_state_ff == LB_PTR) begin
              ptr_ff      <= shift_ff;
              lb_state_ff <= LB_PACK;
            end else begin
              ptr_ff      <= ptr_ff + 1'b1;
              lb_state_ff <= LB_WACK;
            end
          end
        end
        LB_AACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= '0;
            if (rw_ff) begin
              tx_ff       <= rd_byte;
              sda_oe_ff   <= !rd_byte[7];
              ptr_ff      <= ptr_ff + 1'b1;
              lb_state_ff <= LB_RDAT;
            end else begin
              sda_oe_ff   <= 1'b0;
              lb_state_ff <= LB_PTR;
            end
          end
        end
        LB_PACK, LB_WACK: begin
          if (scl_fall) begin
            bit_cnt_ff  <= '0;
            sda_oe_ff   <= 1'b0;
            lb_state_ff <= LB_WDAT;
          end
        end
        LB_RDAT: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end else if (scl_fall) begin
            if (byte_done) begin
              sda_oe_ff   <= 1'b0;
              lb_state_ff <= LB_RACK;
            end else begin
              tx_ff     <= {tx_ff[6:0], 1'b0};
              sda_oe_ff <= !tx_ff[6];
            end
          end
        end
        LB_RACK: begin
          if (scl_rise) begin
            rw_ff <= !local_bus_dat_in;
          end else if (scl_fall) begin
            bit_cnt_ff <= '0;
            if (rw_ff) begin
              tx_ff       <= rd_byte;
              sda_oe_ff   <= !rd_byte[7];
              ptr_ff      <= ptr_ff + 1'b1;
              lb_state_ff <= LB_RDAT;
            end else begin
              lb_state_ff <= LB_IDLE;
            end
          end
        end
        default: begin
          lb_state_ff <= LB_IDLE;
        end
      endcase
    end
  end

  assign local_bus_clk_out = 1'b0;
  assign local_bus_clk_oe  = 1'b0;
  assign local_bus_dat_out = 1'b0;
  assign local_bus_dat_oe  = sda_oe_ff;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg_ff <= {NUM_SINK{SINK_CTRL_RST}};
      pwr_en_ff   <= SINK_PWR_RST;
    end else if (wr_stb) begin
      if (ptr_ff == REG_SINK1_CTRL) begin
        ctrl_reg_ff[0] <= shift_ff[4:0];
      end else if (ptr_ff == REG_SINK2_CTRL) begin
        ctrl_reg_ff[1] <= shift_ff[4:0];
      end else if (ptr_ff == REG_SINK_PWR) begin
        pwr_en_ff <= shift_ff[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-sink switching
  // ----------------------------------------------------------------------
  vpsc_sink_ctrl_s [NUM_SINK-1:0]             eff_ctrl;
  logic            [NUM_SINK-1:0][NUM_SRC-1:0] sel_hot;
  logic                                        eff_pwr_en;
  vpsc_ddc_s       [NUM_SINK-1:0]             sink_ddc_oe_ff;
  vpsc_ddc_s       [NUM_SRC-1:0]              src_ddc_oe_ff;

  // Pin mode ignores the power register and leaves sink power to the source.
  assign eff_pwr_en = ctrl_source_sel ? 1'b1 : pwr_en_ff;

  for (genvar j = 0; j < NUM_SINK; j++) begin : g_sink
    logic      sel_pwr;
    vpsc_ddc_s src_lvl;
    vpsc_ddc_s src_own;

    assign eff_ctrl[j] = ctrl_source_sel ? ctrl_pins_in[j] : ctrl_reg_ff[j];
    assign sel_hot[j]  = src_onehot(eff_ctrl[j].src_sel);
    assign sel_pwr     = src_power_sense[eff_ctrl[j].src_sel];
    assign src_lvl     = src_ddc_in[eff_ctrl[j].src_sel];
    assign src_own     = src_ddc_oe_ff[eff_ctrl[j].src_sel];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sink_lane_sel[j]  <= '0;
        sink_lane_en[j]   <= 1'b0;
        sink_deemph_en[j] <= 1'b0;
        sink_power_out[j] <= 1'b0;
      end else begin
        sink_lane_sel[j]  <= eff_ctrl[j].src_sel;
        sink_lane_en[j]   <= !eff_ctrl[j].lane_oe_n && sel_pwr;
        sink_deemph_en[j] <= eff_ctrl[j].deemph_en;
        sink_power_out[j] <= sel_pwr && eff_pwr_en;
      end
    end

    // Only lows that the device does not drive itself are forwarded.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sink_ddc_oe_ff[j] <= '0;
      end else begin
        sink_ddc_oe_ff[j].scl <= eff_ctrl[j].ddc_drive_en && !src_lvl.scl && !src_own.scl;
        sink_ddc_oe_ff[j].sda <= eff_ctrl[j].ddc_drive_en && !src_lvl.sda && !src_own.sda;
      end
    end

    a_lane_enable_gate: assert property (sink_lane_en[j] == $past(!eff_ctrl[j].lane_oe_n
      && src_power_sense[eff_ctrl[j].src_sel])) else $error("lane enable wrong");
    a_lane_sel_route: assert property (##1 sink_lane_sel[j] == $past(eff_ctrl[j].src_sel))
      else $error("lane select not routed");
    a_deemph_follow: assert property ($changed(eff_ctrl[j].deemph_en) |=>
      sink_deemph_en[j] == $past(eff_ctrl[j].deemph_en)) else $error("deemph lag");
    a_sink_power_out: assert property (sink_power_out[j] |->
      $past(src_power_sense[eff_ctrl[j].src_sel] && eff_pwr_en))
      else $error("sink power without cause");
    a_ddc_drive_off: assert property (!eff_ctrl[j].ddc_drive_en |=> sink_ddc_oe[j] == '0)
      else $error("sink DDC driven while disabled");
  end

  // ----------------------------------------------------------------------
  // Per-source hot-plug and DDC return path
  // ----------------------------------------------------------------------
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    logic hp_any;
    logic scl_low;
    logic sda_low;

    always_comb begin
      hp_any  = 1'b0;
      scl_low = 1'b0;
      sda_low = 1'b0;
      for (int k = 0; k < NUM_SINK; k++) begin
        if (sel_hot[k][s]) begin
          hp_any  = hp_any  | sink_hotplug_in[k];
          scl_low = scl_low | (!sink_ddc_in[k].scl && !sink_ddc_oe_ff[k].scl);
          sda_low = sda_low | (!sink_ddc_in[k].sda && !sink_ddc_oe_ff[k].sda);
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        src_hotplug_out[s] <= 1'b0;
        src_ddc_oe_ff[s]   <= '0;
      end else begin
        src_hotplug_out[s]   <= hp_any;
        src_ddc_oe_ff[s].scl <= src_power_sense[s] && scl_low;
        src_ddc_oe_ff[s].sda <= src_power_sense[s] && sda_low;
      end
    end

    a_hotplug_unsel: assert property (!(sel_hot[0][s] || sel_hot[1][s]) |=>
      !src_hotplug_out[s]) else $error("unselected hot-plug high");
    a_hotplug_follow: assert property (sel_hot[0][s] && sink_hotplug_in[0] |=>
      src_hotplug_out[s]) else $error("hot-plug not followed");
    a_src_ddc_power: assert property (src_ddc_oe[s] != '0 |-> $past(src_power_sense[s]))
      else $error("source DDC driven unpowered");
  end

  assign src_ddc_oe   = src_ddc_oe_ff;
  assign src_ddc_out  = '0;
  assign sink_ddc_oe  = sink_ddc_oe_ff;
  assign sink_ddc_out = '0;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_pin_mode_quiet: assert property (ctrl_source_sel |=> !local_bus_dat_oe)
    else $error("bus pin driven in pin mode");
  a_reg_pwr_write: assert property (wr_stb && ptr_ff == REG_SINK_PWR |=>
    pwr_en_ff == $past(shift_ff[0])) else $error("power enable not written");
  a_reg_ctrl_write: assert property (wr_stb && ptr_ff == REG_SINK1_CTRL |=>
    ctrl_reg_ff[0] == $past(shift_ff[4:0])) else $error("sink one not written");

  c_shared_source: cover property (sel_hot[0] == sel_hot[1] && sink_lane_en == 2'b11);
  c_lane_on: cover property ($rose(sink_lane_en[0]));
  c_reg_write: cover property (wr_stb);
  c_reg_read: cover property (lb_state_ff == LB_RDAT ##1 lb_state_ff == LB_RACK);

endmodule

// File: test/vpsc_far_side.sv
// Far-side model: video sources, display receivers and the local bus wires.
// Assumes open-drain lines with pull-ups and pad pull-downs on power inputs.
`timescale 1ns/1ps
module vpsc_far_side (
  input  wire logic [vpsc_pkg::NUM_SRC-1:0]                src_present, // Source plugged
  input  wire logic [vpsc_pkg::NUM_SRC-1:0]                src_pwr_req, // Source drives power
  output logic      [vpsc_pkg::NUM_SRC-1:0]                src_pwr,     // Power sense level
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0] src_pull,    // Source pulls low
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0] src_oe,      // Device pulls low
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SRC-1:0]      src_lvl,     // Source wire level
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0] snk_pull,   // Receiver pulls low
  input  wire vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0] snk_oe,     // Device pulls low
  output vpsc_pkg::vpsc_ddc_s [vpsc_pkg::NUM_SINK-1:0]     snk_lvl,     // Sink wire level
  input  wire logic [1:0]                                  lb_pull,     // Master pulls clk,dat
  input  wire logic [1:0]                                  lb_oe,       // Device pulls clk,dat
  output logic      [1:0]                                  lb_lvl       // Bus wire levels
);
  import vpsc_pkg::*;
  // An absent source leaves its power pin to the pad pull-down.
  assign src_pwr = src_present & src_pwr_req;
  // Released open-drain lines float up through their pull-ups.
  assign src_lvl = ~(src_pull | src_oe);
  assign snk_lvl = ~(snk_pull | snk_oe);
  assign lb_lvl  = ~(lb_pull | lb_oe);
endmodule

// File: test/vpsc_top_tb.sv
// Self-checking bench of the video port switch control.
// Assumes the far-side model resolves every open-drain wire.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t %s", $time, m); end end
module vpsc_top_tb;
  import vpsc_pkg::*;
  logic                           clk, rst_n, mode;
  vpsc_sink_ctrl_s [NUM_SINK-1:0] pins;
  logic [NUM_SRC-1:0]             present, preq, pwr, hp_out;
  logic [NUM_SINK-1:0]            hp_in, spwr, lane_en, deemph;
  logic [NUM_SINK-1:0][SEL_W-1:0] lane_sel;
  vpsc_ddc_s [NUM_SRC-1:0]        src_pull, src_oe, src_lvl;
  vpsc_ddc_s [NUM_SINK-1:0]       snk_pull, snk_oe, snk_lvl;
  logic [1:0]                     lb_pull, lb_lvl;
  wire  [1:0]                     lb_oe;
  int                             failures, n_checks;
  localparam logic [6:0]          DEV = {LB_ADDR_BASE, 2'h2};

  vpsc_top dut (.clk(clk), .rst_n(rst_n), .ctrl_source_sel(mode), .ctrl_pins_in(pins),
    .local_bus_clk_in(lb_lvl[1]), .local_bus_clk_out(), .local_bus_clk_oe(lb_oe[1]),
    .local_bus_dat_in(lb_lvl[0]), .local_bus_dat_out(), .local_bus_dat_oe(lb_oe[0]),
    .local_addr_bit0(1'b0), .local_addr_bit1(1'b1), .src_power_sense(pwr),
    .src_hotplug_out(hp_out), .sink_hotplug_in(hp_in), .sink_power_out(spwr),
    .sink_lane_sel(lane_sel), .sink_lane_en(lane_en), .sink_deemph_en(deemph),
    .src_ddc_in(src_lvl), .src_ddc_out(), .src_ddc_oe(src_oe), .sink_ddc_in(snk_lvl),
    .sink_ddc_out(), .sink_ddc_oe(snk_oe));

  vpsc_far_side far (.src_present(present), .src_pwr_req(preq), .src_pwr(pwr),
    .src_pull(src_pull), .src_oe(src_oe), .src_lvl(src_lvl), .snk_pull(snk_pull),
    .snk_oe(snk_oe), .snk_lvl(snk_lvl), .lb_pull(lb_pull), .lb_oe(lb_oe), .lb_lvl(lb_lvl));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task settle;
    repeat (3) @(negedge clk);
  endtask

  // Every bus line change is four clocks apart so edges are never ambiguous.
  task lb_half;
    repeat (4) @(negedge clk);
  endtask

  task lb_byte(input logic [7:0] v, output logic k);
    for (int i = 7; i >= 0; i--) begin
      lb_pull[0] = ~v[i];
      lb_half;
      lb_pull[1] = 1'b0;
      lb_half;
      lb_pull[1] = 1'b1;
      lb_half;
    end
    lb_pull[0] = 1'b0;
    lb_half;
    lb_pull[1] = 1'b0;
    lb_half;
    k = ~lb_lvl[0];
    lb_pull[1] = 1'b1;
    lb_half;
  endtask

  task lb_write(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                input logic e);
    logic k;
    lb_pull = 2'b00;
    lb_half;
    lb_pull[0] = 1'b1;
    lb_half;
    lb_pull[1] = 1'b1;
    lb_half;
    lb_byte({a, 1'b0}, k);
    `CHK(k, e, "address ack")
    if (k === 1'b1) begin
      lb_byte(r, k);
      lb_byte(d, k);
    end
    lb_pull[0] = 1'b1;
    lb_half;
    lb_pull[1] = 1'b0;
    lb_half;
    lb_pull[0] = 1'b0;
    lb_half;
  endtask

  // Reads one byte from the current pointer and ends it with a not-acknowledge.
  task lb_read(input logic [6:0] a, output logic [7:0] d);
    logic k;
    lb_pull = 2'b00;
    lb_half;
    lb_pull[0] = 1'b1;
    lb_half;
    lb_pull[1] = 1'b1;
    lb_half;
    lb_byte({a, 1'b1}, k);
    `CHK(k, 1'b1, "read address ack")
    for (int i = 7; i >= 0; i--) begin
      lb_half;
      lb_pull[1] = 1'b0;
      lb_half;
      d[i] = lb_lvl[0];
      lb_pull[1] = 1'b1;
    end
    lb_half;
    lb_pull[1] = 1'b0;
    lb_half;
    lb_pull[1] = 1'b1;
    lb_half;
    lb_pull[0] = 1'b1;
    lb_half;
    lb_pull[1] = 1'b0;
    lb_half;
    lb_pull[0] = 1'b0;
    lb_half;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_bus;
    logic [7:0] rd;
    pins = {5'h13, 5'h13};
    settle;
    `CHK(lane_sel, 4'h0, "pins leaked in bus mode")
    `CHK(spwr, 2'b11, "power enable default")
    lb_write(DEV, REG_SINK_PWR, 8'h00, 1'b1);
    settle;
    `CHK(spwr, 2'b00, "power enable write")
    lb_write(DEV, REG_SINK1_CTRL, 8'h13, 1'b1);
    settle;
    `CHK(lane_sel, 4'h3, "sink one register")
    `CHK(deemph, 2'b01, "register de-emphasis")
    lb_read(DEV, rd);
    `CHK(rd, {3'h0, SINK_CTRL_RST}, "register read back")
    lb_write(DEV ^ 7'h02, REG_SINK2_CTRL, 8'h13, 1'b0);
    settle;
    `CHK(lane_sel, 4'h3, "foreign address wrote")
    mode = 1'b1;
    pins = {5'h04, 5'h01};
    settle;
    `CHK(lane_sel, 4'h1, "pin mode select")
    `CHK(spwr, 2'b11, "power register not ignored")
    lb_write(DEV, REG_SINK2_CTRL, 8'h00, 1'b0);
    mode = 1'b0;
    settle;
    `CHK(lane_sel, 4'h3, "registers lost")
    mode = 1'b1;
  endtask

  task t_route;
    hp_in = 2'b11;
    for (int j = 0; j < 2; j++) begin
      for (int s = 0; s < 4; s++) begin
        pins[j] = {1'(s), 2'b00, 2'(s)};
        pins[1-j] = {3'h1, 2'(3 - s)};
        settle;
        `CHK(lane_sel[j], 2'(s), "lane select")
        `CHK(lane_en, 2'(1 << j), "lane enable")
        `CHK(deemph[j], 1'(s), "de-emphasis")
        `CHK(spwr, 2'b11, "sink power")
        `CHK(hp_out, 4'((1 << s) | (1 << (3 - s))), "hot-plug map")
      end
    end
  endtask

  task t_gate;
    pins = {5'h06, 5'h02};
    hp_in = 2'b10;
    preq = 4'hb;
    settle;
    `CHK(lane_en, 2'b00, "lanes without power")
    `CHK(spwr, 2'b00, "power out without source")
    `CHK(hp_out, 4'h4, "shared hot-plug")
    preq = 4'hf;
    present = 4'hb;
    settle;
    `CHK(spwr, 2'b00, "absent source power")
    present = 4'hf;
    settle;
    `CHK(lane_en, 2'b01, "lanes on")
    pins[0].lane_oe_n = 1'b1;
    hp_in = 2'b00;
    settle;
    `CHK(lane_en, 2'b00, "lanes off")
    `CHK(hp_out, 4'h0, "hot-plug low")
  endtask

  task t_ddc;
    pins = {5'h02, 5'h09};
    src_pull[1].sda = 1'b1;
    src_pull[2].sda = 1'b1;
    settle;
    `CHK(snk_oe, 4'h1, "sink drive gating")
    src_pull = '0;
    snk_pull[0].scl = 1'b1;
    snk_pull[1].scl = 1'b1;
    settle;
    `CHK(snk_oe, 4'h0, "sink release")
    `CHK(src_oe, 8'h28, "source forwarding")
    preq = 4'hd;
    settle;
    `CHK(src_oe, 8'h20, "unpowered source drive")
    snk_pull = '0;
    preq = 4'hf;
    settle;
    `CHK(src_oe, 8'h00, "source release")
  endtask

  // ----------------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------------
  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    mode = 1'b0;
    pins = '0;
    present = 4'hf;
    preq = 4'hf;
    hp_in = 2'b00;
    src_pull = '0;
    snk_pull = '0;
    lb_pull = 2'b00;
    failures = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_bus;
    t_route;
    t_gate;
    t_ddc;
    results;
  end

  initial begin
    #100000;
    failures++;
    results;
  end
endmodule
